// ---- crt_pkg.sv ----
`default_nettype none
package crt_pkg;
    // register byte offsets
    localparam logic [7:0] CRT_OFF_CTRL  = 8'h00;
    localparam logic [7:0] CRT_OFF_MODE  = 8'h04;
    localparam logic [7:0] CRT_OFF_MODE1 = 8'h08;
    localparam logic [7:0] CRT_OFF_CNTL  = 8'h0c;
    localparam logic [7:0] CRT_OFF_CNTH  = 8'h10;
    localparam logic [7:0] CRT_OFF_RCAPL = 8'h14;
    localparam logic [7:0] CRT_OFF_RCAPH = 8'h18;
    // control register fields
    localparam int CRT_C_MAIN  = 7;
    localparam int CRT_C_EXT   = 6;
    localparam int CRT_C_LOWF  = 5;
    localparam int CRT_C_LOWIE = 4;
    localparam int CRT_C_FALL  = 3;
    localparam int CRT_C_HRUN  = 2;
    localparam int CRT_C_CT    = 1;
    localparam int CRT_C_CPRL  = 0;
    // mode register fields
    localparam int CRT_M_SPLIT = 7;
    localparam int CRT_M_LX12  = 6;
    localparam int CRT_M_RISE  = 5;
    localparam int CRT_M_X12   = 4;
    localparam int CRT_M_LRUN  = 3;
    localparam int CRT_M_LCLR  = 2;
    localparam int CRT_M_COE   = 1;
    localparam int CRT_M_MS0   = 0;
    // mode register one fields
    localparam int CRT_N_LCS   = 7;
    localparam int CRT_N_IGN   = 6;
    localparam int CRT_N_VIEW  = 5;
    localparam int CRT_N_CKS   = 4;
    localparam int CRT_N_MS1   = 3;
    localparam int CRT_N_CSEL  = 0;
    // reset values and counts
    localparam logic [7:0] CRT_RST_BYTE = 8'h00;
    localparam logic [3:0] CRT_PRE_LAST = 4'hb;
    localparam logic [7:0] CRT_ONES8    = 8'hff;
    // operating modes
    localparam logic [2:0] CRT_MD_AR   = 3'h0;
    localparam logic [2:0] CRT_MD_ARX  = 3'h1;
    localparam logic [2:0] CRT_MD_CAP  = 3'h2;
    localparam logic [2:0] CRT_MD_CAPZ = 3'h3;
    localparam logic [2:0] CRT_MD_PWM  = 3'h4;
    // clock source codes
    localparam logic [2:0] CRT_CK_DIV12 = 3'h0;
    localparam logic [2:0] CRT_CK_PIN   = 3'h1;
    localparam logic [2:0] CRT_CK_SYS   = 3'h2;
    localparam logic [2:0] CRT_CK_EVT   = 3'h3;
    localparam logic [2:0] CRT_CK_SER   = 3'h4;
    localparam logic [2:0] CRT_CK_T0    = 3'h5;
    localparam logic [2:0] CRT_CK_T1    = 3'h7;
    localparam logic [1:0] CRT_LK_DIV12 = 2'h0;
    localparam logic [1:0] CRT_LK_SYS   = 2'h1;
    localparam logic [1:0] CRT_LK_SER   = 2'h2;
    localparam logic [1:0] CRT_LK_EVT   = 2'h3;
endpackage
`default_nettype wire

// ---- crt_timer.sv ----
// Operation
// - 16-bit counter, timer or event source
// - mode 0 auto-reload, overflow sets flag
// - enabled falling edge sets external flag
// - external input picked from eight sources
// - enabled rising edge acts like falling
// - one-cycle overflow event exported
// - mode 1 reloads from reload pair
// - mode 1 external edge also reloads
// - interrupt request from external flag, main flag unless ignored, low flag if enabled
// - mode 2 edge captures count bytes
// - mode 3 capture then zero count
// - split runs two 8-bit reload counters
// - separate run bits per byte
// - high overflow may clear low run
// - split wraps set main, low flags
// - flags cleared only by software
// - split exports low byte overflow
// - view select maps bits 5..4
// - split modes 1-3 mirror wide modes
// - split mode 4 high byte period
// - pwm overflow loads compare byte
// - pwm reaches pin only when enabled
// - three-bit main clock source code
// - two-bit low byte clock code
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module crt_timer
    import crt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [7:0]  ext_src,
    input  wire logic        count_pin,
    input  wire logic        int_event_in,
    input  wire logic        serial_ovf_in,
    input  wire logic        t0_ovf_in,
    input  wire logic        t1_ovf_in,
    output var  logic        timer_irq,
    output var  logic        overflow_event_out,
    output var  logic        low_overflow_event_out,
    output var  logic        clock_out_pin
);
    // ************************************************************
    // declarations
    // ************************************************************
    logic [8:0]  sy1, sy2, sy3, filt, filt_d;
    logic [8:0]  fall_v, rise_v;
    logic [3:0]  pre;
    logic [7:0]  cnt_l, cnt_h, rcap_l, rcap_h, mode_r, mode1_r;
    logic        main_ovf_flag, external_event_flag, low_overflow_flag;
    logic        low_overflow_irq_enable, falling_edge_enable, high_run_control;
    logic        timer_counter_select, cp_rl, pwm_lvl;
    logic [1:0]  spare;
    logic        div12_tick, ext_evt, hi_src, lo_src, hi_tick, lo_tick;
    logic        ovf16, hi_ovf, lo_ovf, split, pwm, cap, capz, arx, view;
    logic [2:0]  mode, hi_code;
    logic [1:0]  lo_code;
    logic [15:0] cnt16;
    logic        wr_en, rd_go;
    logic [7:0]  rd_byte;

    // true for an aligned, mapped register offset
    function automatic logic crt_hit(input logic [7:0] a);
        crt_hit = (a == CRT_OFF_CTRL) || (a == CRT_OFF_MODE) ||
                  (a == CRT_OFF_MODE1) || (a == CRT_OFF_CNTL) ||
                  (a == CRT_OFF_CNTH) || (a == CRT_OFF_RCAPL) ||
                  (a == CRT_OFF_RCAPH);
    endfunction

    // ************************************************************
    // apb slave
    // ************************************************************
    // one wait state: data and ready are both flopped
    assign rd_go = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite & crt_hit(paddr);

    // read mux, bits 5..4 of control follow the view select
    always_comb begin
        rd_byte = CRT_RST_BYTE;
        if (paddr == CRT_OFF_CTRL) begin
            rd_byte = {main_ovf_flag, external_event_flag,
                       view ? {low_overflow_flag, low_overflow_irq_enable} : spare,
                       falling_edge_enable, high_run_control,
                       timer_counter_select, cp_rl};
        end else if (paddr == CRT_OFF_MODE) begin
            rd_byte = mode_r;
        end else if (paddr == CRT_OFF_MODE1) begin
            rd_byte = mode1_r;
        end else if (paddr == CRT_OFF_CNTL) begin
            rd_byte = cnt_l;
        end else if (paddr == CRT_OFF_CNTH) begin
            rd_byte = cnt_h;
        end else if (paddr == CRT_OFF_RCAPL) begin
            rd_byte = rcap_l;
        end else if (paddr == CRT_OFF_RCAPH) begin
            rd_byte = rcap_h;
        end
    end

    // ready, read data and error answer
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_go;
            pslverr <= rd_go & ~crt_hit(paddr);
            if (rd_go) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ************************************************************
    // input conditioning
    // ************************************************************
    // three stages, level accepted once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            sy1    <= 9'h000;
            sy2    <= 9'h000;
            sy3    <= 9'h000;
            filt   <= 9'h000;
            filt_d <= 9'h000;
        end else begin
            sy1    <= {count_pin, ext_src};
            sy2    <= sy1;
            sy3    <= sy2;
            filt   <= (sy2 & sy3) | (filt & (sy2 ^ sy3));
            filt_d <= filt;
        end
    end

    assign fall_v  = filt_d & ~filt;
    assign rise_v  = filt & ~filt_d;
    // pick one of eight sources, then apply edge enables
    assign ext_evt = (falling_edge_enable & fall_v[mode1_r[CRT_N_CSEL +: 3]]) |
                     (mode_r[CRT_M_RISE] & rise_v[mode1_r[CRT_N_CSEL +: 3]]);

    // ************************************************************
    // clock selection
    // ************************************************************
    // divide-by-twelve prescaler
    always_ff @(posedge clk) begin
        if (srst) begin
            pre <= 4'h0;
        end else if (div12_tick) begin
            pre <= 4'h0;
        end else begin
            pre <= pre + 4'h1;
        end
    end

    assign div12_tick = (pre == CRT_PRE_LAST);
    assign split   = mode_r[CRT_M_SPLIT];
    assign view    = mode1_r[CRT_N_VIEW];
    assign mode    = {mode1_r[CRT_N_MS1], cp_rl, mode_r[CRT_M_MS0]};
    assign pwm     = split & (mode == CRT_MD_PWM);
    assign cap     = (mode == CRT_MD_CAP) | (mode == CRT_MD_CAPZ);
    assign capz    = (mode == CRT_MD_CAPZ);
    assign arx     = (mode == CRT_MD_ARX);
    assign hi_code = {mode1_r[CRT_N_CKS], mode_r[CRT_M_X12], timer_counter_select};
    assign lo_code = {mode1_r[CRT_N_LCS], mode_r[CRT_M_LX12]};
    assign cnt16   = {cnt_h, cnt_l};

    // low byte count source
    always_comb begin
        case (lo_code)
            CRT_LK_DIV12: lo_src = div12_tick;
            CRT_LK_SYS:   lo_src = 1'b1;
            CRT_LK_SER:   lo_src = serial_ovf_in;
            default:      lo_src = int_event_in;
        endcase
    end

    assign lo_tick = split & ~pwm & mode_r[CRT_M_LRUN] & lo_src;
    assign lo_ovf  = lo_tick & (cnt_l == CRT_ONES8);

    // main count source, code 011 takes low overflow when split
    always_comb begin
        case (hi_code)
            CRT_CK_DIV12: hi_src = div12_tick;
            CRT_CK_PIN:   hi_src = fall_v[8];
            CRT_CK_SYS:   hi_src = 1'b1;
            CRT_CK_EVT:   hi_src = split ? lo_ovf : int_event_in;
            CRT_CK_SER:   hi_src = serial_ovf_in;
            CRT_CK_T0:    hi_src = t0_ovf_in;
            CRT_CK_T1:    hi_src = t1_ovf_in;
            default:      hi_src = 1'b0;
        endcase
    end

    assign hi_tick = high_run_control & hi_src;
    assign ovf16   = ~split & hi_tick & (cnt16 == 16'hffff);
    assign hi_ovf  = split & hi_tick & (cnt_h == CRT_ONES8);

    // ************************************************************
    // counter bytes
    // ************************************************************
    // high byte: write, zero, edge reload, overflow reload, count
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_h <= CRT_RST_BYTE;
        end else if (wr_en && paddr == CRT_OFF_CNTH) begin
            cnt_h <= pwdata[7:0];
        end else if (capz && ext_evt) begin
            cnt_h <= CRT_RST_BYTE;
        end else if (arx && ext_evt) begin
            cnt_h <= rcap_h;
        end else if (ovf16 || hi_ovf) begin
            cnt_h <= cap ? CRT_RST_BYTE : rcap_h;
        end else if (hi_tick && (split || cnt_l == CRT_ONES8)) begin
            cnt_h <= cnt_h + 8'h01;
        end
    end

    // low byte: in pwm it holds the compare value
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_l <= CRT_RST_BYTE;
        end else if (wr_en && paddr == CRT_OFF_CNTL) begin
            cnt_l <= pwdata[7:0];
        end else if (pwm && hi_ovf) begin
            cnt_l <= rcap_l;
        end else if (capz && ext_evt) begin
            cnt_l <= CRT_RST_BYTE;
        end else if (arx && ext_evt) begin
            cnt_l <= rcap_l;
        end else if (ovf16 || lo_ovf) begin
            cnt_l <= cap ? CRT_RST_BYTE : rcap_l;
        end else if (split ? lo_tick : hi_tick) begin
            cnt_l <= cnt_l + 8'h01;
        end
    end

    // reload/capture pair, capture wins over a write
    always_ff @(posedge clk) begin
        if (srst) begin
            rcap_l <= CRT_RST_BYTE;
            rcap_h <= CRT_RST_BYTE;
        end else if (cap && ext_evt) begin
            rcap_l <= cnt_l;
            rcap_h <= cnt_h;
        end else if (wr_en) begin
            if (paddr == CRT_OFF_RCAPL) begin
                rcap_l <= pwdata[7:0];
            end else if (paddr == CRT_OFF_RCAPH) begin
                rcap_h <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // control and flags
    // ************************************************************
    // flags: hardware set wins, only software clears
    always_ff @(posedge clk) begin
        if (srst) begin
            main_ovf_flag       <= 1'b0;
            external_event_flag <= 1'b0;
            low_overflow_flag   <= 1'b0;
        end else begin
            if (ovf16 || hi_ovf) begin
                main_ovf_flag <= 1'b1;
            end else if (wr_en && paddr == CRT_OFF_CTRL) begin
                main_ovf_flag <= pwdata[CRT_C_MAIN];
            end
            if (ext_evt) begin
                external_event_flag <= 1'b1;
            end else if (wr_en && paddr == CRT_OFF_CTRL) begin
                external_event_flag <= pwdata[CRT_C_EXT];
            end
            if (lo_ovf) begin
                low_overflow_flag <= 1'b1;
            end else if (wr_en && paddr == CRT_OFF_CTRL && view) begin
                low_overflow_flag <= pwdata[CRT_C_LOWF];
            end
        end
    end

    // plain control bits
    always_ff @(posedge clk) begin
        if (srst) begin
            low_overflow_irq_enable <= 1'b0;
            spare                   <= 2'h0;
            falling_edge_enable     <= 1'b0;
            high_run_control        <= 1'b0;
            timer_counter_select    <= 1'b0;
            cp_rl                   <= 1'b0;
            mode1_r                 <= CRT_RST_BYTE;
        end else if (wr_en && paddr == CRT_OFF_CTRL) begin
            if (view) begin
                low_overflow_irq_enable <= pwdata[CRT_C_LOWIE];
            end else begin
                spare <= pwdata[CRT_C_LOWIE +: 2];
            end
            falling_edge_enable  <= pwdata[CRT_C_FALL];
            high_run_control     <= pwdata[CRT_C_HRUN];
            timer_counter_select <= pwdata[CRT_C_CT];
            cp_rl                <= pwdata[CRT_C_CPRL];
        end else if (wr_en && paddr == CRT_OFF_MODE1) begin
            mode1_r <= pwdata[7:0];
        end
    end

    // mode register, high overflow may stop the low byte
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= CRT_RST_BYTE;
        end else begin
            if (wr_en && paddr == CRT_OFF_MODE) begin
                mode_r <= pwdata[7:0];
            end
            if (hi_ovf && mode_r[CRT_M_LCLR]) begin
                mode_r[CRT_M_LRUN] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_irq              <= 1'b0;
            overflow_event_out     <= 1'b0;
            low_overflow_event_out <= 1'b0;
            pwm_lvl                <= 1'b0;
            clock_out_pin          <= 1'b0;
        end else begin
            timer_irq <= (main_ovf_flag & ~mode1_r[CRT_N_IGN]) | external_event_flag |
                         (low_overflow_flag & low_overflow_irq_enable);
            overflow_event_out     <= split ? lo_ovf : ovf16;
            low_overflow_event_out <= lo_ovf;
            if (hi_tick) begin
                pwm_lvl <= (cnt_h < cnt_l);
            end
            clock_out_pin <= pwm & mode_r[CRT_M_COE] & pwm_lvl;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence wide_wrap_s;
        ovf16 && !wr_en && !ext_evt && mode == CRT_MD_AR;
    endsequence

    // an edge not followed by a software write to control
    sequence ext_kept_s;
        ext_evt ##1 !(wr_en && paddr == CRT_OFF_CTRL);
    endsequence

    // a lone low wrap, so the exported pulse must end
    sequence low_wrap_s;
        split && lo_ovf ##1 split && !lo_ovf;
    endsequence

    reload_wide_a: assert property (wide_wrap_s |=> cnt16 == $past({rcap_h, rcap_l}))
        else $error("wide overflow did not reload");
    ext_flag_a: assert property (ext_kept_s |-> external_event_flag [*2])
        else $error("external flag not held");
    capture_a: assert property (cap && ext_evt |=> {rcap_h, rcap_l} == $past(cnt16))
        else $error("capture missed count");
    zero_a: assert property (capz && ext_evt && !wr_en |=> cnt16 == 16'h0000)
        else $error("auto zero failed");
    sticky_a: assert property (main_ovf_flag && !wr_en |=> main_ovf_flag)
        else $error("overflow flag dropped");
    low_stop_a: assert property (hi_ovf && mode_r[CRT_M_LCLR] |=> !mode_r[CRT_M_LRUN])
        else $error("low run not cleared");
    export_a: assert property (low_wrap_s |-> overflow_event_out ##1 !overflow_event_out)
        else $error("low overflow not exported");
    pwm_load_a: assert property (pwm && hi_ovf && !wr_en |=> cnt_l == $past(rcap_l))
        else $error("compare byte not loaded");
    pin_gate_a: assert property (!mode_r[CRT_M_COE] [*2] |-> !clock_out_pin)
        else $error("pwm reached pin while gated");
    irq_a: assert property ($rose(external_event_flag) |=> timer_irq)
        else $error("no interrupt request");
endmodule // crt_timer
`default_nettype wire

// ---- crt_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// far side: event sources and neighbours
// ****************************************
module crt_partner (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] lvl,
    output var  logic [7:0] ext_src,
    output var  logic       count_pin,
    output var  logic       int_event_in,
    output var  logic       serial_ovf_in,
    output var  logic       t0_ovf_in,
    output var  logic       t1_ovf_in
);
    logic [7:0] tick;

    // external event inputs follow the bench's chosen levels
    assign ext_src = lvl;

    // free-running tick paces the neighbour pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            tick <= 8'h00;
        end else begin
            tick <= tick + 8'h01;
        end
    end

    // one-cycle overflow pulses every 8, 16, 32 and 64 cycles, pin toggles slowly
    always_ff @(posedge clk) begin
        if (srst) begin
            int_event_in  <= 1'b0;
            serial_ovf_in <= 1'b0;
            t0_ovf_in     <= 1'b0;
            t1_ovf_in     <= 1'b0;
            count_pin     <= 1'b0;
        end else begin
            int_event_in  <= (tick[2:0] == 3'h7);
            serial_ovf_in <= (tick[3:0] == 4'hb);
            t0_ovf_in     <= (tick[4:0] == 5'h13);
            t1_ovf_in     <= (tick[5:0] == 6'h2d);
            count_pin     <= tick[3];
        end
    end
endmodule // crt_partner
`default_nettype wire

// ---- capture_reload_timer_with_split_pwm_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module capture_reload_timer_with_split_pwm_tb
    import crt_pkg::*;
;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, lvl;
    logic [31:0] pwdata, prdata;
    logic [7:0]  ext_src;
    logic        count_pin, int_event_in, serial_ovf_in, t0_ovf_in, t1_ovf_in;
    logic        timer_irq, overflow_event_out, low_overflow_event_out, clock_out_pin;
    int          bad_count, cmp_count, ov_n, lo_n, hi_n;
    logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    // counts from each source over 192 edges: main codes 0..7, then low codes 0..3
    logic [7:0]  src_n [12] = '{8'h10, 8'h0c, 8'hc0, 8'h18, 8'h0c, 8'h06, 8'h00, 8'h03,
                                8'h10, 8'hc0, 8'h0c, 8'h18};

    // ****************************************
    // design, partner and clock
    // ****************************************
    crt_timer dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_src(ext_src), .count_pin(count_pin), .int_event_in(int_event_in),
        .serial_ovf_in(serial_ovf_in), .t0_ovf_in(t0_ovf_in), .t1_ovf_in(t1_ovf_in),
        .timer_irq(timer_irq), .overflow_event_out(overflow_event_out),
        .low_overflow_event_out(low_overflow_event_out), .clock_out_pin(clock_out_pin));
    crt_partner partner (.clk(clk), .srst(srst), .lvl(lvl), .ext_src(ext_src),
        .count_pin(count_pin), .int_event_in(int_event_in), .serial_ovf_in(serial_ovf_in),
        .t0_ovf_in(t0_ovf_in), .t1_ovf_in(t1_ovf_in));

    always #10 clk = ~clk;

    // pulse counters on the exported events
    always @(posedge clk) begin
        if (overflow_event_out === 1'b1) ov_n++;
        if (low_overflow_event_out === 1'b1) lo_n++;
    end

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) bad_count++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic experr = 1'b0);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 8'h00, q, e);
        `CHK($sformatf("reg %h", a), {24'h000000, exp}, q)
        `CHK($sformatf("err %h", a), experr, e)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic clean(input string nm);
        wr(CRT_OFF_CTRL, 8'h00); wr(CRT_OFF_MODE, 8'h00); wr(CRT_OFF_MODE1, 8'h00);
        $display("test %s done", nm);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        lvl = 8'h00; bad_count = 0; cmp_count = 0;
        cyc(2);
        srst <= 1'b0;
        // reset values and refused addresses
        foreach (offs[i]) rd(offs[i], CRT_RST_BYTE);
        rd(8'h1c, 8'h00, 1'b1);
        rd(8'h01, 8'h00, 1'b1);
        $display("test reset done");
        // every count source over 192 counted edges, a whole number of its periods
        for (int c = 0; c < 12; c++) begin
            wr(CRT_OFF_MODE1, 8'(c < 8 ? (c & 4) << 2 : (c & 2) << 6));
            wr(CRT_OFF_CNTL, 8'h00);
            wr(CRT_OFF_CNTH, 8'h00);
            wr(c < 8 ? CRT_OFF_MODE : CRT_OFF_CTRL, 8'(c < 8 ? (c & 2) << 3 : 0));
            wr(c < 8 ? CRT_OFF_CTRL : CRT_OFF_MODE,
               8'(c < 8 ? 4 | (c & 1) << 1 : 8'h88 | (c & 1) << 6));
            cyc(188);
            wr(c < 8 ? CRT_OFF_CTRL : CRT_OFF_MODE, 8'h00);
            rd(CRT_OFF_CNTL, src_n[c]);
        end
        clean("sources");
        // mode 0 on system clock: overflow, reload, flag, event, ignore
        wr(CRT_OFF_CNTL, 8'hf0); wr(CRT_OFF_CNTH, 8'hff); wr(CRT_OFF_RCAPH, 8'h80);
        wr(CRT_OFF_MODE, 8'h10);
        ov_n = 0;
        wr(CRT_OFF_CTRL, 8'h04);
        cyc(40);
        rd(CRT_OFF_CTRL, 8'h84);
        rd(CRT_OFF_CNTH, 8'h80);
        `CHK("ovf pulses", 1, ov_n)
        `CHK("irq", 1'b1, timer_irq)
        wr(CRT_OFF_MODE1, 8'h40);
        cyc(3);
        `CHK("irq ignored", 1'b0, timer_irq)
        rd(CRT_OFF_CTRL, 8'h84);
        clean("mode0");
        cyc(3);
        `CHK("irq cleared", 1'b0, timer_irq)
        // capture mode 2 on each of eight sources, rising edges only
        for (int s = 0; s < 8; s++) begin
            wr(CRT_OFF_MODE1, 8'(s)); wr(CRT_OFF_CTRL, 8'h01); wr(CRT_OFF_MODE, 8'h20);
            wr(CRT_OFF_CNTL, 8'(s + 1)); wr(CRT_OFF_CNTH, 8'h5a);
            lvl <= ~(8'h01 << s);
            cyc(10);
            rd(CRT_OFF_CTRL, 8'h01);
            lvl <= 8'hff;
            cyc(10);
            rd(CRT_OFF_CTRL, 8'h41);
            rd(CRT_OFF_RCAPL, 8'(s + 1));
            rd(CRT_OFF_RCAPH, 8'h5a);
            lvl <= 8'h00;
            cyc(10);
            wr(CRT_OFF_CTRL, 8'h01);
        end
        clean("capture");
        // mode 3: falling edge captures then zeroes
        wr(CRT_OFF_CTRL, 8'h09); wr(CRT_OFF_MODE, 8'h01);
        wr(CRT_OFF_CNTL, 8'h12); wr(CRT_OFF_CNTH, 8'h34);
        lvl <= 8'h01;
        cyc(10);
        rd(CRT_OFF_CTRL, 8'h09);
        lvl <= 8'h00;
        cyc(10);
        rd(CRT_OFF_CTRL, 8'h49);
        rd(CRT_OFF_RCAPL, 8'h12); rd(CRT_OFF_RCAPH, 8'h34);
        rd(CRT_OFF_CNTL, 8'h00); rd(CRT_OFF_CNTH, 8'h00);
        clean("autozero");
        // mode 1: falling edge reloads the stopped count
        wr(CRT_OFF_CTRL, 8'h08); wr(CRT_OFF_MODE, 8'h01);
        wr(CRT_OFF_RCAPL, 8'hcd); wr(CRT_OFF_RCAPH, 8'hab);
        wr(CRT_OFF_CNTL, 8'h34); wr(CRT_OFF_CNTH, 8'h12);
        lvl <= 8'h01;
        cyc(10);
        lvl <= 8'h00;
        cyc(10);
        rd(CRT_OFF_CNTL, 8'hcd); rd(CRT_OFF_CNTH, 8'hab);
        rd(CRT_OFF_CTRL, 8'h48);
        clean("reload");
        // split: low wraps first, then high wrap stops the low byte
        wr(CRT_OFF_CNTL, 8'hf8); wr(CRT_OFF_CNTH, 8'he0);
        wr(CRT_OFF_RCAPL, 8'h10); wr(CRT_OFF_RCAPH, 8'h20);
        wr(CRT_OFF_MODE1, 8'h20); wr(CRT_OFF_MODE, 8'hd4);
        ov_n = 0; lo_n = 0;
        wr(CRT_OFF_CTRL, 8'h04); wr(CRT_OFF_MODE, 8'hdc);
        cyc(60);
        rd(CRT_OFF_MODE, 8'hd4);
        rd(CRT_OFF_CTRL, 8'ha4);
        `CHK("low pulses", 1, lo_n)
        `CHK("split ovf pulses", 1, ov_n)
        rd(CRT_OFF_CNTL, 8'h24);
        clean("split");
        // split pwm: period 16, compare f4, four high cycles each period
        wr(CRT_OFF_RCAPH, 8'hf0); wr(CRT_OFF_RCAPL, 8'hf4); wr(CRT_OFF_CNTH, 8'hf0);
        wr(CRT_OFF_MODE1, 8'h08); wr(CRT_OFF_MODE, 8'h92); wr(CRT_OFF_CTRL, 8'h04);
        cyc(40);
        hi_n = 0;
        repeat (160) begin @(posedge clk); if (clock_out_pin === 1'b1) hi_n++; end
        `CHK("pwm high cycles", 40, hi_n)
        rd(CRT_OFF_CNTL, 8'hf4);
        rd(CRT_OFF_CTRL, 8'h84);
        wr(CRT_OFF_MODE, 8'h90);
        cyc(3);
        hi_n = 0;
        repeat (32) begin @(posedge clk); if (clock_out_pin === 1'b1) hi_n++; end
        `CHK("pwm gated", 0, hi_n)
        clean("pwm");
        wrap_up();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule // capture_reload_timer_with_split_pwm_tb
`default_nettype wire
